// file: design/icx_pkg.sv
// Summary of operation
// R1 - eight external pin request inputs, own paths
// R2 - per pin: low, falling, rising, both edges
// R3 - optional noise filter on pins and nmi
// R4 - peripheral detection type fixed in hardware
// R5 - software trigger write raises one request
// R6 - programmable priority, highest pending request wins
// R7 - only one source on the fast path
// R8 - route bit picks cpu or transfer controller
// R9 - nmi pin edge selectable, falling or rising
// R10 - nmi from osc stop, watchdog, two monitors
// R11 - two event link vectors from event input
// R12 - sleep modes wake on nmi or enabled request
// R13 - standby wakes on nmi, pins, rtc only
// R14 - edge requests latch until taken, levels follow
package icx_pkg;

	// ==========================================================
	// sizes and source numbering
	localparam int NSRC    = 16;
	localparam int NEXT    = 8;
	localparam int NPER    = 5;
	localparam int NNMI    = 5;
	localparam int IDW     = 4;
	localparam int PRW     = 4;
	localparam int NEV     = 4;

	localparam logic [3:0] SRC_SW      = 4'h8;
	localparam logic [3:0] SRC_ELA     = 4'h9;
	localparam logic [3:0] SRC_ELB     = 4'hA;
	localparam logic [3:0] SRC_RTC_ALM = 4'hB;
	localparam logic [3:0] SRC_RTC_PRD = 4'hC;
	localparam int         SRC_PER0    = 11;

	// peripheral inputs 0..4 map to sources 11..15; set bits are level type
	localparam logic [4:0] PER_LEVEL = 5'h18;

	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [7:0] OFF_DETECT  = 8'h00;
	localparam logic [7:0] OFF_FILTER  = 8'h04;
	localparam logic [7:0] OFF_SWTRIG  = 8'h08;
	localparam logic [7:0] OFF_XFER    = 8'h0C;
	localparam logic [7:0] OFF_PRIO_LO = 8'h10;
	localparam logic [7:0] OFF_PRIO_HI = 8'h14;
	localparam logic [7:0] OFF_FAST    = 8'h18;
	localparam logic [7:0] OFF_IEN     = 8'h1C;
	localparam logic [7:0] OFF_PEND    = 8'h20;
	localparam logic [7:0] OFF_NMI     = 8'h24;
	localparam logic [7:0] OFF_EVSTAT  = 8'h28;
	localparam logic [7:0] OFF_EVMASK  = 8'h2C;

	// field positions
	localparam int FLT_NMI_EN  = 8;
	localparam int FLT_NMI_EDG = 9;
	localparam int FAST_EN     = 4;
	localparam int EV_WAKE     = 0;
	localparam int EV_XFER     = 1;
	localparam int EV_FAST     = 2;
	localparam int EV_NMI      = 3;

	// reset values
	localparam logic [15:0] RST_DETECT = 16'h0000;
	localparam logic [9:0]  RST_FILTER = 10'h000;
	localparam logic [15:0] RST_XFER   = 16'h0000;
	localparam logic [31:0] RST_PRIO   = 32'h0000_0000;
	localparam logic [4:0]  RST_FAST   = 5'h00;
	localparam logic [15:0] RST_IEN    = 16'h0000;
	localparam logic        PIN_IDLE   = 1'b1;

	// ==========================================================
	// timing: filter sample period and derived clock count
	localparam int CLK_PERIOD_NS   = 10;
	localparam int FILT_SAMPLE_NS  = 80;
	localparam int FILT_DIV        = (FILT_SAMPLE_NS + CLK_PERIOD_NS - 1)
	                                 / CLK_PERIOD_NS;
	localparam int FILT_SAMPLES    = 3;

	// ==========================================================
	// modes
	typedef enum logic [1:0] {
		DET_LOW  = 2'h0,
		DET_FALL = 2'h1,
		DET_RISE = 2'h2,
		DET_BOTH = 2'h3
	} icx_det_e;

	typedef enum logic [1:0] {
		PM_RUN   = 2'h0,
		PM_SLEEP = 2'h1,
		PM_DEEP  = 2'h3,
		PM_STBY  = 2'h2
	} icx_pmode_e;

endpackage

// file: design/icx_filter.sv
`timescale 1ns/1ns
module icx_filter (
	input  wire logic ref_clk_i,
	input  wire logic rst_b_i,
	input  wire logic tick_i,
	input  wire logic filt_en_i,
	input  wire logic pin_i,
	output logic      level_o
);
	import icx_pkg::*;

	// ==========================================================
	// sample history
	logic [FILT_SAMPLES-1:0] hist;
	wire                     all_hi = &hist;
	wire                     all_lo = ~|hist;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			hist <= {FILT_SAMPLES{PIN_IDLE}};
		end else if (tick_i) begin
			hist <= {hist[FILT_SAMPLES-2:0], pin_i};
		end
	end

	// ==========================================================
	// output level: a glitch shorter than all samples never passes
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			level_o <= PIN_IDLE;
		end else if (!filt_en_i) begin
			level_o <= pin_i;
		end else if (all_hi) begin
			level_o <= 1'b1;
		end else if (all_lo) begin
			level_o <= 1'b0;
		end
	end

endmodule // icx_filter

// file: design/icx_ctrl.sv
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ns
module icx_ctrl (
	input  wire logic                        ref_clk_i,
	input  wire logic                        rst_b_i,
	// apb slave
	input  wire logic [7:0]                  paddr_i,
	input  wire logic                        psel_i,
	input  wire logic                        penable_i,
	input  wire logic                        pwrite_i,
	input  wire logic [31:0]                 pwdata_i,
	output logic [31:0]                      prdata_o,
	output logic                             pready_o,
	output logic                             pslverr_o,
	// request sources
	input  wire logic [icx_pkg::NEXT-1:0]    ext_pin_irq_i,
	input  wire logic                        nmi_pin_i,
	input  wire logic [icx_pkg::NPER-1:0]    periph_req_i,
	input  wire logic                        event_link_vector_a_i,
	input  wire logic                        event_link_vector_b_i,
	input  wire logic                        osc_stop_i,
	input  wire logic                        independent_watchdog_i,
	input  wire logic                        voltage_monitor_one_i,
	input  wire logic                        voltage_monitor_two_i,
	input  wire icx_pkg::icx_pmode_e         power_mode_i,
	// cpu and transfer controller
	input  wire logic                        cpu_ack_i,
	input  wire logic                        fast_ack_i,
	input  wire logic                        xfer_ack_i,
	output logic                             cpu_irq_o,
	output logic [icx_pkg::IDW-1:0]          cpu_irq_id_o,
	output logic [icx_pkg::PRW-1:0]          cpu_irq_lvl_o,
	output logic                             fast_irq_o,
	output logic                             xfer_req_o,
	output logic [icx_pkg::IDW-1:0]          xfer_id_o,
	output logic                             nmi_o,
	output logic [icx_pkg::NNMI-1:0]         nmi_src_o,
	output logic                             wake_o,
	output logic                             irq_o
);
	import icx_pkg::*;

	// ==========================================================
	// registers
	logic [15:0]     det_cfg;
	logic [9:0]      filt_cfg;
	logic [NSRC-1:0] transfer_request_enable;
	logic [31:0]     prio_lo;
	logic [31:0]     prio_hi;
	logic [4:0]      fast_cfg;
	logic [NSRC-1:0] ien;
	logic [NNMI-1:0] nmi_stat;
	logic [NEV-1:0]  ev_stat;
	logic [NEV-1:0]  ev_mask;

	// ==========================================================
	// apb decode: zero wait states, unmapped offsets answer pslverr
	wire acc     = psel_i & penable_i;
	wire wr      = acc & pwrite_i;
	wire setup   = psel_i & ~penable_i;
	wire hit_det = paddr_i == OFF_DETECT;
	wire hit_flt = paddr_i == OFF_FILTER;
	wire hit_sw  = paddr_i == OFF_SWTRIG;
	wire hit_xfr = paddr_i == OFF_XFER;
	wire hit_plo = paddr_i == OFF_PRIO_LO;
	wire hit_phi = paddr_i == OFF_PRIO_HI;
	wire hit_fst = paddr_i == OFF_FAST;
	wire hit_ien = paddr_i == OFF_IEN;
	wire hit_pnd = paddr_i == OFF_PEND;
	wire hit_nmi = paddr_i == OFF_NMI;
	wire hit_evs = paddr_i == OFF_EVSTAT;
	wire hit_evm = paddr_i == OFF_EVMASK;
	wire mapped  = hit_det | hit_flt | hit_sw | hit_xfr | hit_plo
	             | hit_phi | hit_fst | hit_ien | hit_pnd | hit_nmi
	             | hit_evs | hit_evm;

	assign pready_o  = 1'b1;
	assign pslverr_o = acc & ~mapped;

	wire sw_set = wr & hit_sw & pwdata_i[0]; // R5

	logic [NSRC-1:0] pend;

	wire [31:0] rd_mux =
		hit_det ? {16'h0000, det_cfg} :
		hit_flt ? {22'h00_0000, filt_cfg} :
		hit_xfr ? {16'h0000, transfer_request_enable} :
		hit_plo ? prio_lo :
		hit_phi ? prio_hi :
		hit_fst ? {27'h000_0000, fast_cfg} :
		hit_ien ? {16'h0000, ien} :
		hit_pnd ? {16'h0000, pend} :
		hit_nmi ? {27'h000_0000, nmi_stat} :
		hit_evs ? {28'h000_0000, ev_stat} :
		hit_evm ? {28'h000_0000, ev_mask} : 32'h0000_0000;

	// read data is captured in the setup cycle so it stands from a flop
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (setup) begin
			prdata_o <= rd_mux;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			det_cfg                 <= RST_DETECT;
			filt_cfg                <= RST_FILTER;
			transfer_request_enable <= RST_XFER;
			prio_lo                 <= RST_PRIO;
			prio_hi                 <= RST_PRIO;
			fast_cfg                <= RST_FAST;
			ien                     <= RST_IEN;
			ev_mask                 <= '0;
		end else if (wr) begin
			if (hit_det) det_cfg <= pwdata_i[15:0]; // R2
			if (hit_flt) filt_cfg <= pwdata_i[9:0]; // R3
			if (hit_xfr) transfer_request_enable <= pwdata_i[15:0]; // R8
			if (hit_plo) prio_lo <= pwdata_i; // R6
			if (hit_phi) prio_hi <= pwdata_i; // R6
			if (hit_fst) fast_cfg <= pwdata_i[4:0]; // R7
			if (hit_ien) ien <= pwdata_i[15:0];
			if (hit_evm) ev_mask <= pwdata_i[NEV-1:0];
		end
	end

	// ==========================================================
	// filter sample clock: one-cycle enable from a divider
	logic [7:0] div_cnt;
	wire        filt_tick = div_cnt == 8'(FILT_DIV - 1);

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			div_cnt <= 8'h00;
		end else begin
			div_cnt <= filt_tick ? 8'h00 : div_cnt + 8'h01;
		end
	end

	// ==========================================================
	// pin filters: eight external pins plus the nmi pin
	logic [NEXT:0] pin_raw;
	logic [NEXT:0] pin_flt;
	logic [NEXT:0] pin_prev;
	logic [NEXT:0] flt_en;

	assign pin_raw = {nmi_pin_i, ext_pin_irq_i};
	assign flt_en  = {filt_cfg[FLT_NMI_EN], filt_cfg[NEXT-1:0]};

	genvar p;
	generate
		for (p = 0; p <= NEXT; p++) begin : g_pin
			icx_filter u_flt ( // R3
				.ref_clk_i (ref_clk_i),
				.rst_b_i   (rst_b_i),
				.tick_i    (filt_tick),
				.filt_en_i (flt_en[p]),
				.pin_i     (pin_raw[p]),
				.level_o   (pin_flt[p])
			);
		end
	endgenerate

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			pin_prev <= {(NEXT+1){PIN_IDLE}};
		end else begin
			pin_prev <= pin_flt;
		end
	end

	wire [NEXT:0] pin_rise = pin_flt & ~pin_prev;
	wire [NEXT:0] pin_fall = ~pin_flt & pin_prev;

	// ==========================================================
	// event inputs and non-maskable sources, edge detected
	logic [1:0]      el_prev;
	logic [NNMI-2:0] nm_prev;
	wire  [1:0]      el_in = {event_link_vector_b_i, event_link_vector_a_i};
	wire  [NNMI-2:0] nm_in = {voltage_monitor_two_i, voltage_monitor_one_i,
	                          independent_watchdog_i, osc_stop_i};
	wire  [1:0]      el_hit = el_in & ~el_prev; // R11
	wire             nmi_pin_hit = filt_cfg[FLT_NMI_EDG] ? pin_rise[NEXT]
	                                                     : pin_fall[NEXT]; // R9
	wire  [NNMI-1:0] nmi_set = {nm_in & ~nm_prev, nmi_pin_hit}; // R10
	wire  [NNMI-1:0] nmi_clr = (wr & hit_nmi) ? pwdata_i[NNMI-1:0]
	                                          : '0;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			el_prev  <= 2'h0;
			nm_prev  <= '0;
			nmi_stat <= '0;
		end else begin
			el_prev  <= el_in;
			nm_prev  <= nm_in;
			nmi_stat <= (nmi_stat & ~nmi_clr) | nmi_set; // R10
		end
	end

	// non-maskable: no enable or mask can hold these back
	assign nmi_o     = |nmi_stat;
	assign nmi_src_o = nmi_stat;

	// ==========================================================
	// per-source request shaping and pending state
	logic [NSRC-1:0] is_level;
	logic [NSRC-1:0] lvl_req;
	logic [NSRC-1:0] edge_hit;
	logic [NSRC-1:0] latch;
	logic [NSRC-1:0] taken;
	logic [NPER-1:0] per_prev;

	wire [2*NSRC*2-1:0] prio_all = {prio_hi, prio_lo};
	wire [IDW-1:0]      fast_id  = fast_cfg[IDW-1:0];
	wire                fast_en  = fast_cfg[FAST_EN];

	genvar s;
	generate
		for (s = 0; s < NSRC; s++) begin : g_src
			if (s < NEXT) begin : g_ext
				wire [1:0] md = det_cfg[2*s+1:2*s];
				assign is_level[s] = md == DET_LOW; // R2
				assign lvl_req[s]  = ~pin_flt[s];
				assign edge_hit[s] = (md == DET_FALL) ? pin_fall[s] :
				                     (md == DET_RISE) ? pin_rise[s] :
				                     (md == DET_BOTH) ? (pin_rise[s] |
				                                         pin_fall[s])
				                                      : 1'b0; // R1
			end else if (s == SRC_SW) begin : g_sw
				assign is_level[s] = 1'b0;
				assign lvl_req[s]  = 1'b0;
				assign edge_hit[s] = sw_set; // R5
			end else if (s < SRC_PER0) begin : g_el
				assign is_level[s] = 1'b0;
				assign lvl_req[s]  = 1'b0;
				assign edge_hit[s] = el_hit[s - SRC_ELA]; // R11
			end else begin : g_per
				// detection type wired per source, software cannot change it
				assign is_level[s] = PER_LEVEL[s - SRC_PER0]; // R4
				assign lvl_req[s]  = periph_req_i[s - SRC_PER0];
				assign edge_hit[s] = periph_req_i[s - SRC_PER0] &
				                     ~per_prev[s - SRC_PER0];
			end

			assign taken[s] = (cpu_ack_i & cpu_irq_o &
			                   cpu_irq_id_o == IDW'(s))
			                | (fast_ack_i & fast_irq_o & fast_id == IDW'(s))
			                | (xfer_ack_i & xfer_req_o &
			                   xfer_id_o == IDW'(s));

			// a new edge in the cycle of acceptance is kept
			always_ff @(posedge ref_clk_i) begin
				if (!rst_b_i) begin
					latch[s] <= 1'b0;
				end else begin
					latch[s] <= edge_hit[s] | (latch[s] & ~taken[s]); // R14
				end
			end

			assign pend[s] = is_level[s] ? lvl_req[s] : latch[s]; // R14
		end
	endgenerate

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			per_prev <= '0;
		end else begin
			per_prev <= periph_req_i;
		end
	end

	// ==========================================================
	// arbitration: level 0 disables, ties go to the lower number
	wire [NSRC-1:0] on_fast  = fast_en ? (NSRC'(1) << fast_id) : '0;
	wire [NSRC-1:0] cand_cpu = pend & ien & ~transfer_request_enable
	                         & ~on_fast; // R7 R8
	wire [NSRC-1:0] cand_xfr = pend & ien & transfer_request_enable; // R8

	logic           cpu_found;
	logic [IDW-1:0] cpu_best;
	logic [PRW-1:0] cpu_blvl;
	logic           xfr_found;
	logic [IDW-1:0] xfr_best;
	logic [PRW-1:0] xfr_blvl;

	always_comb begin
		cpu_found = 1'b0;
		cpu_best  = '0;
		cpu_blvl  = '0;
		xfr_found = 1'b0;
		xfr_best  = '0;
		xfr_blvl  = '0;
		for (int i = 0; i < NSRC; i++) begin
			if (cand_cpu[i] && prio_all[PRW*i +: PRW] > cpu_blvl) begin
				cpu_found = 1'b1; // R6
				cpu_best  = IDW'(i);
				cpu_blvl  = prio_all[PRW*i +: PRW];
			end
			if (cand_xfr[i] && prio_all[PRW*i +: PRW] > xfr_blvl) begin
				xfr_found = 1'b1; // R6
				xfr_best  = IDW'(i);
				xfr_blvl  = prio_all[PRW*i +: PRW];
			end
		end
	end

	// an accepting cycle drops the request so no stale id repeats
	wire fast_pend = fast_en & pend[fast_id] & ien[fast_id]
	               & ~transfer_request_enable[fast_id]; // R7

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			cpu_irq_o     <= 1'b0;
			cpu_irq_id_o  <= '0;
			cpu_irq_lvl_o <= '0;
			fast_irq_o    <= 1'b0;
			xfer_req_o    <= 1'b0;
			xfer_id_o     <= '0;
		end else begin
			cpu_irq_o     <= cpu_found & ~(cpu_ack_i & cpu_irq_o); // R6
			cpu_irq_id_o  <= cpu_best;
			cpu_irq_lvl_o <= cpu_blvl;
			fast_irq_o    <= fast_pend & ~(fast_ack_i & fast_irq_o); // R7
			xfer_req_o    <= xfr_found & ~(xfer_ack_i & xfer_req_o); // R8
			xfer_id_o     <= xfr_best;
		end
	end

	// ==========================================================
	// wake-up out of low-power modes
	wire any_en   = |(pend & ien);
	wire stby_src = |(pend[NEXT-1:0] & ien[NEXT-1:0])
	              | (pend[SRC_RTC_ALM] & ien[SRC_RTC_ALM])
	              | (pend[SRC_RTC_PRD] & ien[SRC_RTC_PRD]); // R13
	wire sleepy   = power_mode_i == PM_SLEEP || power_mode_i == PM_DEEP;
	wire next_wake = (sleepy & (nmi_o | any_en)) // R12
	               | (power_mode_i == PM_STBY & (nmi_o | stby_src)); // R13

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			wake_o <= 1'b0;
		end else begin
			wake_o <= next_wake;
		end
	end

	// ==========================================================
	// block events: sticky, write one to clear, set wins
	wire [NEV-1:0] ev_set = {|nmi_set, fast_ack_i & fast_irq_o,
	                         xfer_ack_i & xfer_req_o, next_wake & ~wake_o};
	wire [NEV-1:0] ev_clr = (wr & hit_evs) ? pwdata_i[NEV-1:0] : '0;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			ev_stat <= '0;
		end else begin
			ev_stat <= (ev_stat & ~ev_clr) | ev_set;
		end
	end

	assign irq_o = |(ev_stat & ev_mask);

endmodule // icx_ctrl

// file: dv/icx_ctrl_assertions.sv
`timescale 1ns/1ns
module icx_ctrl_assertions
	import icx_pkg::*;
(
	input logic                ref_clk_i,
	input logic                rst_b_i,
	input logic [7:0]          paddr_i,
	input logic                psel_i,
	input logic                penable_i,
	input logic                pready_o,
	input logic                pslverr_o,
	input logic                osc_stop_i,
	input logic                independent_watchdog_i,
	input icx_pkg::icx_pmode_e power_mode_i,
	input logic                cpu_ack_i,
	input logic                xfer_ack_i,
	input logic                cpu_irq_o,
	input logic [3:0]          cpu_irq_id_o,
	input logic [3:0]          cpu_irq_lvl_o,
	input logic                fast_irq_o,
	input logic                xfer_req_o,
	input logic                nmi_o,
	input logic [4:0]          nmi_src_o,
	input logic                wake_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);

	// ==========================================================
	// decode
	wire bad_addr = (paddr_i > OFF_EVMASK) || (paddr_i[1:0] != 2'h0);

	// ==========================================================
	// checks
	a_bad_addr: assert property (psel_i && penable_i |->
		pslverr_o == bad_addr) else $error("slave error flag wrong");
	a_ready_high: assert property (psel_i && penable_i |-> pready_o)
		else $error("access not completed");
	a_nmi_merge: assert property (nmi_o == (|nmi_src_o))
		else $error("nmi output not the or of its flags");
	a_osc_nmi: assert property (
		$rose(osc_stop_i) |-> ##[1:3] nmi_src_o[1])
		else $error("oscillator stop flag not raised");
	a_wdt_nmi: assert property (
		$rose(independent_watchdog_i) |-> ##[1:3] nmi_src_o[2])
		else $error("watchdog flag not raised");
	a_ack_drop: assert property (cpu_irq_o && cpu_ack_i |=> !cpu_irq_o)
		else $error("cpu request kept after accept");
	a_xfer_drop: assert property (
		xfer_req_o && xfer_ack_i |=> !xfer_req_o)
		else $error("transfer request kept after accept");
	a_prio_nonzero: assert property (
		cpu_irq_o |-> cpu_irq_lvl_o != 4'h0)
		else $error("request with level zero");
	a_sw_hold: assert property (
		cpu_irq_o && !cpu_ack_i && cpu_irq_id_o == SRC_SW |=> cpu_irq_o)
		else $error("latched request lost without accept");
	a_wake_nmi: assert property (
		nmi_o && power_mode_i != PM_RUN |=> wake_o)
		else $error("no wake on nmi");

	c_cpu_ack: cover property (cpu_irq_o && cpu_ack_i);
	c_xfer_ack: cover property (xfer_req_o && xfer_ack_i);
	c_fast: cover property (fast_irq_o);
	c_wake: cover property ($rose(wake_o));
endmodule // icx_ctrl_assertions

bind icx_ctrl icx_ctrl_assertions u_chk (
	.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .paddr_i(paddr_i),
	.psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .osc_stop_i(osc_stop_i),
	.independent_watchdog_i(independent_watchdog_i),
	.power_mode_i(power_mode_i), .cpu_ack_i(cpu_ack_i),
	.xfer_ack_i(xfer_ack_i), .cpu_irq_o(cpu_irq_o),
	.cpu_irq_id_o(cpu_irq_id_o), .cpu_irq_lvl_o(cpu_irq_lvl_o),
	.fast_irq_o(fast_irq_o), .xfer_req_o(xfer_req_o), .nmi_o(nmi_o),
	.nmi_src_o(nmi_src_o), .wake_o(wake_o)
);

// file: dv/icx_partner.sv
`timescale 1ns/1ns
module icx_partner (
	input  wire logic       ref_clk_i,
	input  wire logic       rst_b_i,
	input  wire logic       ack_en_i,
	input  wire logic [3:0] ack_dly_i,
	input  wire logic [2:0] req_i,
	output logic [2:0]      ack_o
);
	logic [3:0] cnt [3];

	// ==========================================================
	// accept pulses: cpu, fast path, transfer controller
	// delay only runs while enabled, so a held-off accept stays slow
	always_ff @(posedge ref_clk_i) begin
		for (int k = 0; k < 3; k++) begin
			if (!rst_b_i || !req_i[k] || ack_o[k]) begin
				cnt[k] <= 4'h0;
				ack_o[k] <= 1'h0;
			end else if (ack_en_i) begin
				if (cnt[k] >= ack_dly_i) begin
					ack_o[k] <= 1'h1;
				end else begin
					cnt[k] <= cnt[k] + 4'h1;
				end
			end
		end
	end
endmodule // icx_partner

// file: dv/icx_ctrl_test.sv
`timescale 1ns/1ns
module icx_ctrl_test;
	import icx_pkg::*;

	typedef struct packed {
		icx_det_e det;
		logic     start;
		logic     fin;
		logic     hit;
	} icx_row_s;

	logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, rerr;
	logic [7:0]  paddr, ext_pin;
	logic [31:0] pwdata, prdata, rdat;
	logic        nmi_pin, ev_a, ev_b, osc, wdt, mon1, mon2, ack_en;
	logic [4:0]  periph, nmi_src;
	logic [2:0]  acks;
	logic [3:0]  ack_dly, cpu_id, cpu_lvl, xfer_id;
	logic        cpu_irq, fast_irq, xfer_req, nmi, wake, irq;
	icx_pmode_e  pmode;
	int          err_total = 0;
	int          cmp_count = 0;
	icx_row_s    rows [8] = '{
		'{DET_LOW, 1'h1, 1'h0, 1'h1}, '{DET_LOW, 1'h1, 1'h1, 1'h0},
		'{DET_FALL, 1'h1, 1'h0, 1'h1}, '{DET_FALL, 1'h0, 1'h1, 1'h0},
		'{DET_RISE, 1'h0, 1'h1, 1'h1}, '{DET_RISE, 1'h1, 1'h0, 1'h0},
		'{DET_BOTH, 1'h1, 1'h0, 1'h1}, '{DET_BOTH, 1'h0, 1'h1, 1'h1}};

	icx_ctrl dut (
		.ref_clk_i(clk), .rst_b_i(rst_b), .paddr_i(paddr), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.ext_pin_irq_i(ext_pin), .nmi_pin_i(nmi_pin), .periph_req_i(periph),
		.event_link_vector_a_i(ev_a), .event_link_vector_b_i(ev_b),
		.osc_stop_i(osc), .independent_watchdog_i(wdt),
		.voltage_monitor_one_i(mon1), .voltage_monitor_two_i(mon2),
		.power_mode_i(pmode), .cpu_ack_i(acks[0]), .fast_ack_i(acks[1]),
		.xfer_ack_i(acks[2]), .cpu_irq_o(cpu_irq), .cpu_irq_id_o(cpu_id),
		.cpu_irq_lvl_o(cpu_lvl), .fast_irq_o(fast_irq),
		.xfer_req_o(xfer_req), .xfer_id_o(xfer_id), .nmi_o(nmi),
		.nmi_src_o(nmi_src), .wake_o(wake), .irq_o(irq));

	icx_partner u_cpu (
		.ref_clk_i(clk), .rst_b_i(rst_b), .ack_en_i(ack_en),
		.ack_dly_i(ack_dly), .req_i({xfer_req, fast_irq, cpu_irq}),
		.ack_o(acks));

	// ==========================================================
	// helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// request held until pready is seen high at a rising edge
	// no local limit: only the watchdog ends a stalled wait
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1) begin
			@(posedge clk);
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		apb(1'h0, a, 32'h0);
	endtask

	// sample just after an edge so registered outputs have landed
	task automatic at(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic setup();
		wr(OFF_IEN, 32'h0000_FFFF);
		wr(OFF_PRIO_LO, 32'h0000_0032);
		wr(OFF_PRIO_HI, 32'h0201_1543);
	endtask

	task automatic close_out();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ==========================================================
	// clock and watchdog
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		close_out();
	end

	// ==========================================================
	// tests
	initial begin
		{rst_b, psel, penable, pwrite, ev_a, ev_b, osc, wdt} = 8'h00;
		{mon1, mon2, ack_dly, periph} = 11'h000;
		{paddr, pwdata} = 40'h0;
		ext_pin = 8'hFF;
		nmi_pin = 1'h1;
		ack_en = 1'h1;
		pmode = PM_RUN;
		repeat (3) @(posedge clk);
		rst_b <= 1'h1;
		setup();
		foreach (rows[i]) begin
			wr(OFF_DETECT, {30'h0, rows[i].det});
			@(posedge clk);
			ext_pin[0] <= rows[i].start;
			at(12);
			@(posedge clk);
			ack_en <= 1'h0;
			ext_pin[0] <= rows[i].fin;
			at(6);
			chk(cpu_irq, rows[i].hit);
			rd(OFF_PEND);
			chk(rdat[0], rows[i].hit);
			@(posedge clk);
			ack_en <= 1'h1;
			ext_pin[0] <= 1'h1;
		end
		$display("test detect done");
		@(posedge clk);
		rst_b <= 1'h0;
		repeat (3) @(posedge clk);
		rst_b <= 1'h1;
		for (int a = 0; a < 12; a++) begin
			rd(8'(a * 4));
			chk(rdat, 32'h0);
		end
		rd(8'h30);
		chk(rdat, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		setup();
		$display("test reset done");
		@(posedge clk);
		ack_en <= 1'h0;
		wr(OFF_DETECT, 32'h0000_0004);
		wr(OFF_SWTRIG, 32'h1);
		at(2);
		chk({cpu_irq, cpu_id, cpu_lvl}, {1'h1, SRC_SW, 4'h3});
		@(posedge clk);
		ext_pin[1] <= 1'h0;
		at(4);
		chk(cpu_id, 4'h1);
		@(posedge clk);
		ack_en <= 1'h1;
		ext_pin[1] <= 1'h1;
		at(10);
		chk(cpu_irq, 1'h0);
		$display("test priority done");
		@(posedge clk);
		ack_en <= 1'h0;
		ack_dly <= 4'h4;
		wr(OFF_XFER, 32'h0000_0100);
		wr(OFF_SWTRIG, 32'h1);
		at(2);
		chk({cpu_irq, xfer_req, xfer_id}, {1'h0, 1'h1, SRC_SW});
		@(posedge clk);
		ack_en <= 1'h1;
		at(12);
		chk(xfer_req, 1'h0);
		wr(OFF_XFER, 32'h0);
		$display("test route done");
		@(posedge clk);
		ack_en <= 1'h0;
		ack_dly <= 4'h0;
		wr(OFF_FAST, 32'h0000_0018);
		wr(OFF_SWTRIG, 32'h1);
		at(2);
		chk({fast_irq, cpu_irq, irq}, 3'h4);
		@(posedge clk);
		ack_en <= 1'h1;
		at(4);
		chk(fast_irq, 1'h0);
		wr(OFF_EVMASK, 32'h4);
		at(1);
		chk(irq, 1'h1);
		wr(OFF_EVSTAT, 32'h4);
		at(1);
		chk(irq, 1'h0);
		wr(OFF_FAST, 32'h0);
		$display("test fast done");
		@(posedge clk);
		nmi_pin <= 1'h0;
		at(4);
		chk(nmi_src, 5'h01);
		@(posedge clk);
		{osc, wdt, mon1, mon2} <= 4'hF;
		at(4);
		chk({nmi, nmi_src}, 6'h3F);
		@(posedge clk);
		pmode <= PM_STBY;
		at(2);
		chk(wake, 1'h1);
		@(posedge clk);
		pmode <= PM_RUN;
		wr(OFF_NMI, 32'h1F);
		wr(OFF_FILTER, 32'h200);
		@(posedge clk);
		nmi_pin <= 1'h1;
		at(4);
		chk(nmi_src, 5'h01);
		wr(OFF_NMI, 32'h1F);
		at(1);
		chk(nmi, 1'h0);
		$display("test nmi done");
		@(posedge clk);
		ack_en <= 1'h0;
		pmode <= PM_STBY;
		wr(OFF_SWTRIG, 32'h1);
		at(3);
		chk(wake, 1'h0);
		@(posedge clk);
		pmode <= PM_SLEEP;
		at(2);
		chk(wake, 1'h1);
		@(posedge clk);
		pmode <= PM_DEEP;
		at(2);
		chk(wake, 1'h1);
		@(posedge clk);
		pmode <= PM_STBY;
		periph[0] <= 1'h1;
		at(4);
		chk(wake, 1'h1);
		@(posedge clk);
		pmode <= PM_RUN;
		ack_en <= 1'h1;
		at(10);
		$display("test wake done");
		@(posedge clk);
		ack_en <= 1'h0;
		periph[0] <= 1'h0;
		periph[3] <= 1'h1;
		at(4);
		chk({cpu_irq, cpu_id}, {1'h1, 4'hE});
		@(posedge clk);
		ev_a <= 1'h1;
		at(4);
		chk(cpu_id, SRC_ELA);
		@(posedge clk);
		ev_b <= 1'h1;
		at(4);
		chk(cpu_id, SRC_ELB);
		@(posedge clk);
		ack_en <= 1'h1;
		at(12);
		rd(OFF_PEND);
		chk(rdat, 32'h0000_4000);
		@(posedge clk);
		periph[3] <= 1'h0;
		at(4);
		rd(OFF_PEND);
		chk(rdat, 32'h0);
		$display("test level done");
		// pin 2 has level 0, so its latch shows only in pending
		wr(OFF_FILTER, 32'h0000_0004);
		wr(OFF_DETECT, 32'h0000_0010);
		@(posedge clk);
		ext_pin[2] <= 1'h0;
		@(posedge clk);
		ext_pin[2] <= 1'h1;
		at(40);
		rd(OFF_PEND);
		chk(rdat[2], 1'h0);
		@(posedge clk);
		ext_pin[2] <= 1'h0;
		at(40);
		rd(OFF_PEND);
		chk(rdat[2], 1'h1);
		$display("test filter done");
		close_out();
	end
endmodule // icx_ctrl_test
